// File: shared/port_power_ocs_params.svh
// offsets, field positions, codes and reset values of the port power / over-current selectors
`ifndef PORT_POWER_OCS_PARAMS_SVH
`define PORT_POWER_OCS_PARAMS_SVH

`define PPO_ADDR_W          16
`define PPO_DATA_W          8
`define PPO_PORT3_PWR_ADDR  16'h3c08
`define PPO_PORT4_PWR_ADDR  16'h3c0c
`define PPO_PORT1_OCS_ADDR  16'h3c20

`define PPO_SHARED_PIN_BIT  7
`define PPO_DISABLED_BIT    5
`define PPO_FIXED_DEV_BIT   4

`define PPO_PWR_OFF         4'h0
`define PPO_PWR_USB2        4'h1
`define PPO_PWR_USB3        4'h2
`define PPO_PWR_EITHER      4'h3
`define PPO_PWR_GPIO        4'h4

`define PPO_OCS_OFF         4'h0
`define PPO_OCS_PIN         4'h1
`define PPO_OCS_GPIO        4'h2
`define PPO_OCS_FORCE       4'hf

// power register: bit 6 reads zero; over-current register keeps all eight bits
`define PPO_PWR_RW_MASK     8'hbf
`define PPO_PWR_RESET       8'h00
`define PPO_OCS_RESET       8'h00

`endif

// File: shared/port_power_ocs_pkg.sv
// types shared by the port power / over-current selector block
package port_power_ocs_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic usb2_power;
		logic usb3_power;
		logic gpio_power;
	} power_sources_t;

	typedef struct packed {
		logic power_enable;
		logic shared_pin_mode;
		logic port_disabled;
		logic fixed_attached_device;
	} port_ctrl_t;

endpackage

// File: hw/port_power_ocs_select.sv
// port 3/4 power source selectors and port 1 over-current source selector
//
// Contract
// [RULE1] bit 7 set means power control and over-current sense share one pin, clear means two.
// [RULE2] bit 5 of a power select register marks the port permanently disabled.
// [RULE3] bit 4 of a power select register marks a non-removable attached device.
// [RULE4] selector 0000b turns power off, 0001b follows USB2 power, 0010b follows USB3 power.
// [RULE5] selector 0011b powers when USB2 or USB3 is on, 0100b follows the designated GPIO.
// [RULE6] software must program only the defined selector codes.
// [RULE7] over-current code 0000b disables, 0001b uses the sense pin, 0010b uses a GPIO.
// [RULE8] over-current code 1111b forces the indication active for test.
// [RULE9] software loads these bits from configuration and does not change them in operation.
// [RULE10] disable, non-removable and shared-pin bits are set before enumeration.
// [RULE11] a reserved power code drives power off, and reserved bits read as zero; the over-current register reads bits 7:4 back as written.
`timescale 1ns/1ns
`include "port_power_ocs_params.svh"

module port_power_ocs_select (
	// clock and reset
	input  wire logic                             clk_in,
	input  wire logic                             rst_n_in,
	// register port
	input  wire port_power_ocs_pkg::reg_req_t     req_in,
	output logic [7:0]                            rdata_out,
	// power sources, one set per port (index 0 = port 3, 1 = port 4)
	input  wire port_power_ocs_pkg::power_sources_t port3_src_in,
	input  wire port_power_ocs_pkg::power_sources_t port4_src_in,
	// over-current sources for port 1
	input  wire logic                             overcurrent_sense_in,
	input  wire logic                             overcurrent_gpio_in,
	// port controls
	output port_power_ocs_pkg::port_ctrl_t        port3_ctrl_out,
	output port_power_ocs_pkg::port_ctrl_t        port4_ctrl_out,
	output logic                                  port1_overcurrent_out,
	output logic                                  port1_ocs_disabled_out
);
	import port_power_ocs_pkg::*;

	typedef struct packed {
		logic [1:0][7:0]  pwr_cfg;
		logic [7:0]       ocs_cfg;
		logic [7:0]       rdata;
		port_ctrl_t [1:0] ctrl;
		logic             oc;
		logic             oc_dis;
	} state_t;

	state_t         state_reg;
	state_t         state_next;
	power_sources_t src [2];

	assign src[0] = port3_src_in;
	assign src[1] = port4_src_in;

	////////////////////////////////////////////////////////////////////////
	function automatic logic power_from(input logic [3:0] sel, input power_sources_t s);
		case (sel)
			`PPO_PWR_OFF:    power_from = 1'b0; // RULE4
			`PPO_PWR_USB2:   power_from = s.usb2_power; // RULE4
			`PPO_PWR_USB3:   power_from = s.usb3_power; // RULE4
			`PPO_PWR_EITHER: power_from = s.usb2_power | s.usb3_power; // RULE5
			`PPO_PWR_GPIO:   power_from = s.gpio_power; // RULE5
			default:         power_from = 1'b0; // RULE11
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.rdata = 8'h00;
		// writes take effect at any time; configuration is expected to be static
		if (req_in.wr) begin
			case (req_in.addr)
				`PPO_PORT3_PWR_ADDR: state_next.pwr_cfg[0] = req_in.wdata & `PPO_PWR_RW_MASK; // RULE11
				`PPO_PORT4_PWR_ADDR: state_next.pwr_cfg[1] = req_in.wdata & `PPO_PWR_RW_MASK; // RULE11
				`PPO_PORT1_OCS_ADDR: state_next.ocs_cfg = req_in.wdata;
				default: begin
				end
			endcase
		end
		if (req_in.rd) begin
			case (req_in.addr)
				`PPO_PORT3_PWR_ADDR: state_next.rdata = state_reg.pwr_cfg[0];
				`PPO_PORT4_PWR_ADDR: state_next.rdata = state_reg.pwr_cfg[1];
				`PPO_PORT1_OCS_ADDR: state_next.rdata = state_reg.ocs_cfg;
				default:             state_next.rdata = 8'h00;
			endcase
		end
		for (int i = 0; i < 2; i++) begin
			state_next.ctrl[i].shared_pin_mode = state_reg.pwr_cfg[i][`PPO_SHARED_PIN_BIT]; // RULE1
			state_next.ctrl[i].port_disabled = state_reg.pwr_cfg[i][`PPO_DISABLED_BIT]; // RULE2
			state_next.ctrl[i].fixed_attached_device =
				state_reg.pwr_cfg[i][`PPO_FIXED_DEV_BIT]; // RULE3
			// a disabled port is never powered
			state_next.ctrl[i].power_enable = !state_reg.pwr_cfg[i][`PPO_DISABLED_BIT]
				&& power_from(state_reg.pwr_cfg[i][3:0], src[i]);
		end
		case (state_reg.ocs_cfg[3:0])
			`PPO_OCS_PIN:   state_next.oc = overcurrent_sense_in; // RULE7
			`PPO_OCS_GPIO:  state_next.oc = overcurrent_gpio_in; // RULE7
			`PPO_OCS_FORCE: state_next.oc = 1'b1; // RULE8
			default:        state_next.oc = 1'b0; // RULE7
		endcase
		state_next.oc_dis = (state_reg.ocs_cfg[3:0] == `PPO_OCS_OFF); // RULE7
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_out              = state_reg.rdata;
	assign port3_ctrl_out         = state_reg.ctrl[0];
	assign port4_ctrl_out         = state_reg.ctrl[1];
	assign port1_overcurrent_out  = state_reg.oc;
	assign port1_ocs_disabled_out = state_reg.oc_dis;

	////////////////////////////////////////////////////////////////////////
	a_shared_pin_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE1
		port3_ctrl_out.shared_pin_mode == $past(state_reg.pwr_cfg[0][7]))
		else $error("shared pin mode mismatch");
	a_disabled_no_power: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE2
		port4_ctrl_out.port_disabled |-> !port4_ctrl_out.power_enable)
		else $error("disabled port powered");
	a_fixed_dev_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE3
		req_in.wr && req_in.addr == `PPO_PORT3_PWR_ADDR && !req_in.rd
		|-> ##2 port3_ctrl_out.fixed_attached_device == $past(req_in.wdata[4], 2))
		else $error("fixed device flag not applied");
	// flag bit 7 is free here, bits 5 and 4 are held clear, though only the disable bit gates power
	a_usb2_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE4
		state_reg.pwr_cfg[0][5:0] == 6'h01 |=>
		port3_ctrl_out.power_enable == $past(port3_src_in.usb2_power))
		else $error("usb2 follow failed");
	a_either_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE5
		state_reg.pwr_cfg[1][5:0] == 6'h03 |=>
		port4_ctrl_out.power_enable == $past(port4_src_in.usb2_power | port4_src_in.usb3_power))
		else $error("either source follow failed");
	a_reserved_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE11
		state_reg.pwr_cfg[0][3:0] > 4'h4 |=> !port3_ctrl_out.power_enable)
		else $error("reserved code powered port");
	a_ocs_pin_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
		state_reg.ocs_cfg[3:0] == 4'h1 |=> port1_overcurrent_out == $past(overcurrent_sense_in))
		else $error("sense pin not followed");
	a_ocs_force_on: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE8
		state_reg.ocs_cfg[3:0] == 4'hf [*2] |=> port1_overcurrent_out)
		else $error("forced over-current not active");
	a_read_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE11
		req_in.rd && req_in.addr == `PPO_PORT4_PWR_ADDR |=> !rdata_out[6])
		else $error("reserved bit read as one");

	// mode flags of port 4 follow the stored register one edge later
	a_shared_pin_port4: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE1
		port4_ctrl_out.shared_pin_mode == $past(state_reg.pwr_cfg[1][7]))
		else $error("port 4 shared pin mode mismatch");

	// disable flag of port 3 mirrors bit 5
	a_disabled_flag_port3: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE2
		port3_ctrl_out.port_disabled == $past(state_reg.pwr_cfg[0][5]))
		else $error("port 3 disable flag mismatch");

	// a disabled port must never see power, whatever the selector says
	a_disabled_off_port3: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE2
		port3_ctrl_out.port_disabled |-> !port3_ctrl_out.power_enable)
		else $error("disabled port 3 powered");

	// non-removable flag of port 4 mirrors bit 4
	a_fixed_dev_port4: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE3
		port4_ctrl_out.fixed_attached_device == $past(state_reg.pwr_cfg[1][4]))
		else $error("port 4 fixed device flag mismatch");

	// code zero keeps the switch open even when sources are on
	a_power_off_code: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE4
		state_reg.pwr_cfg[1][3:0] == 4'h0 |=> !port4_ctrl_out.power_enable)
		else $error("port 4 powered with selector off");

	// usb3 source path of port 3
	a_usb3_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE4
		state_reg.pwr_cfg[0][5:0] == 6'h02 |=>
		port3_ctrl_out.power_enable == $past(port3_src_in.usb3_power))
		else $error("usb3 follow failed");

	// general-purpose pin path of port 4
	a_gpio_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE5
		state_reg.pwr_cfg[1][5:0] == 6'h04 |=>
		port4_ctrl_out.power_enable == $past(port4_src_in.gpio_power))
		else $error("gpio power follow failed");

	// over-current taken from the general-purpose pin
	a_ocs_gpio_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
		state_reg.ocs_cfg[3:0] == 4'h2 |=> port1_overcurrent_out == $past(overcurrent_gpio_in))
		else $error("gpio over-current not followed");

	// code zero raises the disabled flag one edge later
	a_ocs_off_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
		state_reg.ocs_cfg[3:0] == 4'h0 |=> port1_ocs_disabled_out)
		else $error("over-current disable flag missing");

	// any other code clears it again
	a_ocs_on_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
		state_reg.ocs_cfg[3:0] != 4'h0 |=> !port1_ocs_disabled_out)
		else $error("over-current disable flag stuck");

	// a disabled sensor path reports nothing
	a_ocs_off_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
		state_reg.ocs_cfg[3:0] == 4'h0 |=> !port1_overcurrent_out)
		else $error("over-current reported while disabled");

	// reserved sensor codes report nothing, so a bad load cannot trip a port
	a_ocs_reserved_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
		state_reg.ocs_cfg[3:0] inside {[4'h3:4'he]} |=> !port1_overcurrent_out)
		else $error("over-current reported on reserved code");

	// reserved power codes on port 4 as well
	a_reserved_off_port4: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE11
		state_reg.pwr_cfg[1][3:0] > 4'h4 |=> !port4_ctrl_out.power_enable)
		else $error("reserved code powered port 4");

	// holes in the map read as zero
	a_unmapped_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE11
		req_in.rd && !(req_in.addr inside {`PPO_PORT3_PWR_ADDR, `PPO_PORT4_PWR_ADDR,
		`PPO_PORT1_OCS_ADDR}) |=> rdata_out == 8'h00)
		else $error("unmapped address read non-zero");

	// read data stands one cycle only, so a stale value cannot be mistaken for an answer
	a_read_data_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!req_in.rd |=> rdata_out == 8'h00)
		else $error("read data without read strobe");

endmodule

// File: verification/port_power_partner.sv
// partner model: port power switches and over-current sensors
`timescale 1ns/1ns
module port_power_partner (
	// clock and commanded levels
	input  wire logic                          clk_in,
	input  wire logic [7:0]                    levels_in,
	// levels seen by the selectors
	output port_power_ocs_pkg::power_sources_t port3_src_out = '0,
	output port_power_ocs_pkg::power_sources_t port4_src_out = '0,
	output logic                               sense_out = 1'b0,
	output logic                               gpio_out = 1'b0
);
	// levels move only just after an edge, as a settled switch would
	always @(posedge clk_in) begin
		port3_src_out <= levels_in[2:0];
		port4_src_out <= levels_in[5:3];
		sense_out <= levels_in[6];
		gpio_out <= levels_in[7];
	end
endmodule

// File: verification/port_power_ocs_select_bench.sv
// self-checking bench for the port power and over-current selectors
`timescale 1ns/1ns
`include "port_power_ocs_params.svh"
module port_power_ocs_select_bench;
	import port_power_ocs_pkg::*;
	logic           clk_in = 1'b0;
	logic           rst_n_in = 1'b0;
	logic           look = 1'b0;
	reg_req_t       req_in = '0;
	logic [7:0]     lv = 8'h00;
	logic [7:0]     rdata_out, r3, r4, ro, erd;
	logic [15:0]    ra;
	logic [31:0]    seed = 32'h2b58350f;
	power_sources_t s3, s4;
	port_ctrl_t     c3, c4;
	logic           sense, gpio, oc, ocd;
	logic [17:0]    q[$];
	logic [3:0]     pcode[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hf};
	logic [3:0]     ocode[5] = '{4'h0, 4'h1, 4'h2, 4'hf, 4'h7};
	int             fail_count = 0;
	int             comparisons = 0;
	port_power_partner far (.clk_in(clk_in), .levels_in(lv), .port3_src_out(s3),
		.port4_src_out(s4), .sense_out(sense), .gpio_out(gpio));
	port_power_ocs_select dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
		.rdata_out(rdata_out), .port3_src_in(s3), .port4_src_in(s4),
		.overcurrent_sense_in(sense), .overcurrent_gpio_in(gpio), .port3_ctrl_out(c3),
		.port4_ctrl_out(c4), .port1_overcurrent_out(oc), .port1_ocs_disabled_out(ocd));
	always #5 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] ctl(input logic [7:0] r, input logic [2:0] s);
		logic p;
		case (r[3:0])
			`PPO_PWR_USB2: p = s[2];
			`PPO_PWR_USB3: p = s[1];
			`PPO_PWR_EITHER: p = s[2] | s[1];
			`PPO_PWR_GPIO: p = s[0];
			default: p = 1'b0;
		endcase
		return {p & !r[5], r[7], r[5], r[4]};
	endfunction
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		y = y ^ (y << 5);
		return y;
	endfunction
	task automatic check(input logic [17:0] seen, input logic [17:0] want);
		comparisons++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value outputs expected %h seen %h", want, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_in <= '{a, d, w, !w};
		look <= 1'b0;
	endtask
	task automatic finish_read(input logic [17:0] e);
		@(posedge clk_in);
		req_in <= '0;
		look <= 1'b1;
		q.push_back(e);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// reads land one cycle late, so outputs are judged on that same edge
	always @(posedge clk_in) begin
		if (look)
			check({rdata_out, c3, c4, oc, ocd}, q.pop_front());
	end
	initial begin
		#20000;
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		bus(1'b0, `PPO_PORT3_PWR_ADDR, 8'h00);
		finish_read({8'h00, 4'h0, 4'h0, 1'b0, 1'b1});
		for (int i = 0; i < 40; i++) begin
			seed = xorshift(seed);
			r3 = {seed[7:4], pcode[i % 8]};
			r4 = {seed[15:12], pcode[(i + 3) % 8]};
			ro = {seed[23:20], ocode[i % 5]};
			bus(1'b1, `PPO_PORT3_PWR_ADDR, r3);
			lv <= seed[31:24];
			bus(1'b1, `PPO_PORT4_PWR_ADDR, r4);
			bus(1'b1, `PPO_PORT1_OCS_ADDR, ro);
			case (i % 4)
				0: {ra, erd} = {16'(`PPO_PORT3_PWR_ADDR), r3 & `PPO_PWR_RW_MASK};
				1: {ra, erd} = {16'(`PPO_PORT4_PWR_ADDR), r4 & `PPO_PWR_RW_MASK};
				2: {ra, erd} = {16'(`PPO_PORT1_OCS_ADDR), ro};
				default: {ra, erd} = {16'h3c10, 8'h00};
			endcase
			bus(1'b0, ra, 8'h00);
			finish_read({erd, ctl(r3, seed[26:24]), ctl(r4, seed[29:27]),
				ro[3:0] == 4'hf || (ro[3:0] == 4'h1 && seed[30]) || (ro[3:0] == 4'h2 && seed[31]),
				ro[3:0] == 4'h0});
		end
		@(posedge clk_in);
		look <= 1'b0;
		@(posedge clk_in);
		give_verdict();
	end
endmodule
